/* src/pfc_defines.vh */
// Constants for the PCI Express flow control credit block
`ifndef PFC_DEFINES_VH
`define PFC_DEFINES_VH

// ****************************************
// Flow control classes
// ****************************************
`define PFC_CLS_P 2'h0
`define PFC_CLS_NP 2'h1
`define PFC_CLS_CPL 2'h2

// ****************************************
// Receive buffer sizes, in credits; completion buffer, completion boundary and data credit sizes in bytes
// ****************************************
`define PFC_RXH_P 8'h20
`define PFC_RXD_P 12'h100
`define PFC_RXH_NP 8'h20
`define PFC_RXD_NP 12'h010
`define PFC_CPL_BYTES 16'h1000
`define PFC_RCB_BYTES 16'h0040
`define PFC_DCRED_BYTES 16'h0010

// ****************************************
// Scheduling and limits
// ****************************************
`define PFC_MAXPAY_CRED 12'h010
`define PFC_FC_TIMER_US 30
`define PFC_CLK_MHZ 40
`define PFC_FC_TIMER_CYC (`PFC_FC_TIMER_US * `PFC_CLK_MHZ)
`define PFC_TAGS_LO 7'h20
`define PFC_TAGS_HI 7'h40

// ****************************************
// Error severity codes
// ****************************************
`define PFC_ERR_CORR 2'h1
`define PFC_ERR_NONFATAL 2'h2
`define PFC_ERR_FATAL 2'h3

// ****************************************
// Request FIFO shape
// ****************************************
`define PFC_FIFO_W 15
`define PFC_FIFO_DEPTH 8
`define PFC_FIFO_AW 3

`endif

/* src/pfc_fifo.v */
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module pfc_fifo #(
  parameter W = 15,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Fill side
  input wire inValid,
  input wire [W-1:0] inData,
  output reg inReady,
  // Drain side
  output wire outValid,
  output wire [W-1:0] outData,
  input wire outReady
);
  reg [W-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_ff;
  reg [AW-1:0] rdPtr_ff;
  reg [AW:0] cnt_ff;
  reg [AW:0] nxt_cnt;
  wire push;
  wire pop;
  wire [AW:0] depthW;

  assign depthW = DEPTH[AW:0];
  assign outValid = (cnt_ff != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_ff];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  always @* begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + {{AW{1'b0}}, 1'b1};
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - {{AW{1'b0}}, 1'b1};
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem[wrPtr_ff] <= inData;
    end
  end

  // Ready is registered so a full FIFO stalls the source on the next edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      cnt_ff <= {(AW+1){1'b0}};
      inReady <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr_ff <= rdPtr_ff + {{(AW-1){1'b0}}, 1'b1};
      end
      cnt_ff <= nxt_cnt;
      inReady <= (nxt_cnt != depthW);
    end
  end
endmodule // pfc_fifo

/* src/pfc_top.v */
// Flow control credit gate, credit return tracking and FC update scheduler
`timescale 1ns/1ps
`include "pfc_defines.vh"

// How it works
// - Four limit and consumed counters per class
// - Limits load at init, then from updates
// - Send only if header and data credits suffice
// - One header credit plus payload data credits
// - Granted packet adds usage to consumed counters
// - Allocated counters start at free buffer space
// - Allocated grows after application drains packet
// - Update carries current allocated counter values
// - Pending update normally yields to TLPs, DLLPs
// - Starving partner raises update to high priority
// - Thirty microsecond timer raises high priority
// - Quarter buffer freed raises high priority
// - Update never preempts a TLP in flight
// - Stalled packets proceed once limit rises
// - Endpoint advertises infinite completion credits
// - Completion header slots are bytes over 64
// - Outstanding reads bounded by tags times size
// - Errors sorted as correctable, nonfatal, fatal
module pfc_top (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Application transmit requests
  input wire txReqValid,
  input wire [1:0] txReqClass,
  input wire [11:0] txReqDataCred,
  input wire txReqIsRead,
  output wire txReqReady,
  // Link transmit side
  input wire linkTlpReady,
  input wire tlpActive,
  input wire otherDllpPend,
  output reg txGrant_ff,
  output reg [1:0] txGrantClass_ff,
  output reg [11:0] txGrantDataCred_ff,
  // Received flow control DLLPs
  input wire fcInit,
  input wire fcRxUpd,
  input wire [1:0] fcRxClass,
  input wire [7:0] fcRxHdr,
  input wire [11:0] fcRxData,
  // Receive buffer events
  input wire rxRecv,
  input wire [1:0] rxRecvClass,
  input wire [11:0] rxRecvDataCred,
  input wire rxDrain,
  input wire [1:0] rxDrainClass,
  input wire [11:0] rxDrainDataCred,
  // Outgoing FC update request
  output reg fcReq_ff,
  output reg fcHiPri_ff,
  output reg [1:0] fcClass_ff,
  output reg [7:0] fcHdr_ff,
  output reg [11:0] fcData_ff,
  input wire fcAck,
  // Configuration and read tags
  input wire endpointMode,
  input wire tag64En,
  input wire cplTagFree,
  output reg [6:0] tagsInUse_ff,
  // Error classification
  input wire errValid,
  input wire [1:0] errSev,
  output reg errCorr_ff,
  output reg errNonFatal_ff,
  output reg errFatal_ff
);

  // ****************************************
  // Buffer totals per class
  // ****************************************
  function [7:0] rxTotH;
    input [1:0] cls;
    reg [15:0] t;
    begin
      t = `PFC_CPL_BYTES / `PFC_RCB_BYTES;
      if (cls == `PFC_CLS_P) begin
        rxTotH = `PFC_RXH_P;
      end else if (cls == `PFC_CLS_NP) begin
        rxTotH = `PFC_RXH_NP;
      end else begin
        rxTotH = t[7:0];
      end
    end
  endfunction

  function [11:0] rxTotD;
    input [1:0] cls;
    reg [15:0] t;
    begin
      t = `PFC_CPL_BYTES / `PFC_DCRED_BYTES;
      if (cls == `PFC_CLS_P) begin
        rxTotD = `PFC_RXD_P;
      end else if (cls == `PFC_CLS_NP) begin
        rxTotD = `PFC_RXD_NP;
      end else begin
        rxTotD = t[11:0];
      end
    end
  endfunction

  // ****************************************
  // Request FIFO
  // ****************************************
  wire headValid;
  wire [14:0] headWord;
  wire headIsRead;
  wire [1:0] headCls;
  wire [11:0] headNeed;
  wire grantNow;
  wire [2:0] okV;
  wire [2:0] pendV;
  wire [2:0] hiV;
  wire [23:0] allocHBus;
  wire [35:0] allocDBus;
  wire tagOk;
  wire [6:0] tagLimit;
  wire [31:0] tmrMax;

  assign tmrMax = `PFC_FC_TIMER_CYC;
  assign headIsRead = headWord[14];
  assign headCls = headWord[13:12];
  assign headNeed = headWord[11:0];

  pfc_fifo #(
    .W(`PFC_FIFO_W),
    .DEPTH(`PFC_FIFO_DEPTH),
    .AW(`PFC_FIFO_AW)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .inValid(txReqValid),
    .inData({txReqIsRead, txReqClass, txReqDataCred}),
    .inReady(txReqReady),
    .outValid(headValid),
    .outData(headWord),
    .outReady(grantNow)
  );

  // ****************************************
  // Per class credit state
  // ****************************************
  genvar c;
  generate
    for (c = 0; c < 3; c = c + 1) begin : g_cls
      reg [7:0] limH_ff;
      reg [7:0] conH_ff;
      reg [7:0] allocH_ff;
      reg [7:0] sentH_ff;
      reg [11:0] limD_ff;
      reg [11:0] conD_ff;
      reg [11:0] allocD_ff;
      reg [11:0] sentD_ff;
      reg [11:0] recvD_ff;
      reg infH_ff;
      reg infD_ff;
      reg [10:0] tmr_ff;
      localparam [1:0] cls = (c == 0) ? 2'h0 : ((c == 1) ? 2'h1 : 2'h2);
      wire hitTx = grantNow && (headCls == cls);
      wire hitInit = fcInit && (fcRxClass == cls);
      wire hitUpd = fcRxUpd && (fcRxClass == cls);
      wire hitDrain = rxDrain && (rxDrainClass == cls);
      wire hitRecv = rxRecv && (rxRecvClass == cls);
      wire hitAck = fcAck && fcReq_ff && (fcClass_ff == cls);
      // Modular differences stay correct across wraparound
      wire [7:0] availH = limH_ff - conH_ff;
      wire [11:0] availD = limD_ff - conD_ff;
      wire [7:0] freedH = allocH_ff - sentH_ff;
      wire [11:0] freedD = allocD_ff - sentD_ff;
      wire [11:0] partnerD = sentD_ff - recvD_ff;
      wire tmrExp = (tmr_ff == tmrMax[10:0]);
      // Completions are not flow controlled for an endpoint, so the
      // tag limit on reads bounds the completions instead
      wire cplMute = endpointMode && (cls == `PFC_CLS_CPL);
      wire starve = (partnerD < `PFC_MAXPAY_CRED) && (freedD != 12'h000);
      wire quarter = (freedH >= (rxTotH(cls) >> 2)) ||
        (freedD >= (rxTotD(cls) >> 2));

      // Header needs one nonzero credit, data needs the payload credits
      assign okV[c] = (infH_ff || (availH != 8'h00)) &&
        (infD_ff || (availD >= headNeed));
      assign pendV[c] = !cplMute && ((freedH != 8'h00) ||
        (freedD != 12'h000) || tmrExp);
      assign hiV[c] = !cplMute && (starve || tmrExp || quarter);
      // Endpoint advertises zero, which means infinite, for completions
      assign allocHBus[c*8 +: 8] = cplMute ? 8'h00 : allocH_ff;
      assign allocDBus[c*12 +: 12] = cplMute ? 12'h000 : allocD_ff;

      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          limH_ff <= 8'h00;
          limD_ff <= 12'h000;
          infH_ff <= 1'b0;
          infD_ff <= 1'b0;
          conH_ff <= 8'h00;
          conD_ff <= 12'h000;
          allocH_ff <= rxTotH(cls);
          allocD_ff <= rxTotD(cls);
          sentH_ff <= rxTotH(cls);
          sentD_ff <= rxTotD(cls);
          recvD_ff <= 12'h000;
          tmr_ff <= 11'h000;
        end else begin
          if (hitInit) begin
            limH_ff <= fcRxHdr;
            limD_ff <= fcRxData;
            infH_ff <= (fcRxHdr == 8'h00);
            infD_ff <= (fcRxData == 12'h000);
          end else if (hitUpd) begin
            if (!infH_ff) begin
              limH_ff <= fcRxHdr;
            end
            if (!infD_ff) begin
              limD_ff <= fcRxData;
            end
          end
          if (hitTx) begin
            conH_ff <= conH_ff + 8'h01;
            conD_ff <= conD_ff + headNeed;
          end
          if (hitDrain) begin
            allocH_ff <= allocH_ff + 8'h01;
            allocD_ff <= allocD_ff + rxDrainDataCred;
          end
          if (hitRecv) begin
            recvD_ff <= recvD_ff + rxRecvDataCred;
          end
          if (hitAck) begin
            sentH_ff <= fcHdr_ff;
            sentD_ff <= fcData_ff;
            tmr_ff <= 11'h000;
          end else if (!tmrExp) begin
            tmr_ff <= tmr_ff + 11'h001;
          end
        end
      end
    end
  endgenerate

  // ****************************************
  // Transmit gate and read tags
  // ****************************************
  assign tagLimit = tag64En ? `PFC_TAGS_HI : `PFC_TAGS_LO;
  // Holding reads at the tag limit bounds outstanding read data
  assign tagOk = !headIsRead || (tagsInUse_ff < tagLimit);
  // A high priority update takes the next slot ahead of TLPs
  assign grantNow = headValid && okV[headCls] && linkTlpReady && tagOk &&
    !(fcReq_ff && fcHiPri_ff);

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      txGrant_ff <= 1'b0;
      txGrantClass_ff <= 2'h0;
      txGrantDataCred_ff <= 12'h000;
      tagsInUse_ff <= 7'h00;
    end else begin
      txGrant_ff <= grantNow;
      if (grantNow) begin
        txGrantClass_ff <= headCls;
        txGrantDataCred_ff <= headNeed;
      end
      if ((grantNow && headIsRead) && !cplTagFree) begin
        tagsInUse_ff <= tagsInUse_ff + 7'h01;
      end else if (!(grantNow && headIsRead) && cplTagFree &&
        (tagsInUse_ff != 7'h00)) begin
        tagsInUse_ff <= tagsInUse_ff - 7'h01;
      end
    end
  end

  // ****************************************
  // FC update scheduler
  // ****************************************
  reg [1:0] selCls;
  wire hiAny;
  wire pendAny;
  wire raise;

  always @* begin
    selCls = 2'h0;
    if (hiAny) begin
      if (hiV[0]) begin
        selCls = 2'h0;
      end else if (hiV[1]) begin
        selCls = 2'h1;
      end else begin
        selCls = 2'h2;
      end
    end else if (pendV[0]) begin
      selCls = 2'h0;
    end else if (pendV[1]) begin
      selCls = 2'h1;
    end else begin
      selCls = 2'h2;
    end
  end

  assign hiAny = |hiV;
  assign pendAny = |pendV;
  // Low priority waits for idle TLP and DLLP traffic; no start mid-TLP
  assign raise = !fcReq_ff && pendAny && !tlpActive &&
    (hiAny || (!otherDllpPend && !headValid));

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fcReq_ff <= 1'b0;
      fcHiPri_ff <= 1'b0;
      fcClass_ff <= 2'h0;
      fcHdr_ff <= 8'h00;
      fcData_ff <= 12'h000;
    end else if (raise) begin
      fcReq_ff <= 1'b1;
      fcHiPri_ff <= hiAny;
      fcClass_ff <= selCls;
      fcHdr_ff <= allocHBus[selCls*8 +: 8];
      fcData_ff <= allocDBus[selCls*12 +: 12];
    end else if (fcReq_ff && fcAck) begin
      fcReq_ff <= 1'b0;
      fcHiPri_ff <= 1'b0;
    end else if (fcReq_ff) begin
      fcHiPri_ff <= hiV[fcClass_ff];
    end
  end

  // ****************************************
  // Error classification
  // ****************************************
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      errCorr_ff <= 1'b0;
      errNonFatal_ff <= 1'b0;
      errFatal_ff <= 1'b0;
    end else begin
      errCorr_ff <= errValid && (errSev == `PFC_ERR_CORR);
      errNonFatal_ff <= errValid && (errSev == `PFC_ERR_NONFATAL);
      errFatal_ff <= errValid && (errSev == `PFC_ERR_FATAL);
    end
  end
endmodule // pfc_top

/* tb/pfc_link_model.sv */
// Link-side partner: acknowledges FC updates and paces TLP acceptance
`timescale 1ns/1ps
module pfc_link_model (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Update handshake
  input wire fcReq,
  output reg fcAck_ff,
  // Pacing from the bench
  input wire stall,
  input wire slow,
  output wire linkTlpReady
);
  reg [3:0] waitCnt_ff;
  assign linkTlpReady = !stall;
  // Acks a standing request once, so a second ack never hits a new request
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      fcAck_ff <= 1'b0;
      waitCnt_ff <= 4'h0;
    end else begin
      fcAck_ff <= 1'b0;
      if (fcReq && !fcAck_ff) begin
        if (waitCnt_ff >= (slow ? 4'h7 : 4'h0)) begin
          fcAck_ff <= 1'b1;
          waitCnt_ff <= 4'h0;
        end else begin
          waitCnt_ff <= waitCnt_ff + 4'h1;
        end
      end else begin
        waitCnt_ff <= 4'h0;
      end
    end
  end
endmodule // pfc_link_model

/* tb/pfc_top_monitor.sv */
// Concurrent checks on the flow control credit block ports
`timescale 1ns/1ps
module pfc_top_monitor (
  // Clock and reset
  input wire clk,
  input wire rst_b,
  // Inputs watched
  input wire linkTlpReady,
  input wire tlpActive,
  input wire otherDllpPend,
  input wire endpointMode,
  input wire tag64En,
  input wire errValid,
  input wire [1:0] errSev,
  input wire fcAck,
  // Outputs watched
  input wire txGrant_ff,
  input wire fcReq_ff,
  input wire fcHiPri_ff,
  input wire [1:0] fcClass_ff,
  input wire [7:0] fcHdr_ff,
  input wire [11:0] fcData_ff,
  input wire [6:0] tagsInUse_ff,
  input wire errCorr_ff,
  input wire errNonFatal_ff,
  input wire errFatal_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_link_gate: assert property (!linkTlpReady |=> !txGrant_ff)
    else $error("grant while link busy");
  a_hipri_block: assert property (fcReq_ff && fcHiPri_ff
    |=> !txGrant_ff) else $error("grant beside urgent update");
  a_req_hold: assert property (fcReq_ff && !fcAck |=> fcReq_ff
    && $stable(fcHdr_ff) && $stable(fcData_ff) && $stable(fcClass_ff))
    else $error("update request changed before ack");
  a_ack_drop: assert property (fcReq_ff && fcAck |=> !fcReq_ff)
    else $error("update request kept after ack");
  a_no_cpl_upd: assert property (endpointMode && fcReq_ff
    |-> fcClass_ff != 2'h2) else $error("completion update in endpoint");
  a_no_preempt: assert property ($rose(fcReq_ff) |-> $past(!tlpActive))
    else $error("update raised during a TLP");
  a_lowpri_wait: assert property ($rose(fcReq_ff) && !fcHiPri_ff
    |-> $past(!otherDllpPend)) else $error("low update beat a DLLP");
  a_tag_limit: assert property (tagsInUse_ff <=
    (tag64En ? 7'h40 : 7'h20)) else $error("tags above limit");
  a_err_corr: assert property (errValid && errSev == 2'h1
    |=> errCorr_ff && !errNonFatal_ff && !errFatal_ff)
    else $error("correctable sort wrong");
  a_err_idle: assert property ((!errValid || errSev == 2'h0)
    |=> !errCorr_ff && !errNonFatal_ff && !errFatal_ff)
    else $error("error pulse without cause");
endmodule // pfc_top_monitor

/* tb/pfc_top_tb.sv */
// Self-checking bench for the flow control credit block
`timescale 1ns/1ps
`include "pfc_defines.vh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
  n_errors++; $display("[FAIL] t=%0t got %h exp %h", $time, a, b); end end
module pfc_top_tb;
  logic clk, rst_b, txReqValid, txReqIsRead, tlpActive, otherDllpPend;
  logic fcInit, fcRxUpd, rxRecv, rxDrain, endpointMode, tag64En;
  logic cplTagFree, errValid, stall, slow;
  logic [1:0] txReqClass, fcRxClass, rxRecvClass, rxDrainClass, errSev;
  logic [11:0] txReqDataCred, fcRxData, rxRecvDataCred, rxDrainDataCred;
  logic [7:0] fcRxHdr;
  wire txReqReady, linkTlpReady, txGrant_ff, fcReq_ff, fcHiPri_ff, fcAck;
  wire errCorr_ff, errNonFatal_ff, errFatal_ff;
  wire [1:0] txGrantClass_ff, fcClass_ff;
  wire [11:0] txGrantDataCred_ff, fcData_ff;
  wire [7:0] fcHdr_ff;
  wire [6:0] tagsInUse_ff;
  int n_errors = 0, samples_checked = 0, gCnt = 0, cyc = 0;
  pfc_top DUT (.clk(clk), .rst_b(rst_b), .txReqValid(txReqValid),
    .txReqClass(txReqClass), .txReqDataCred(txReqDataCred),
    .txReqIsRead(txReqIsRead), .txReqReady(txReqReady),
    .linkTlpReady(linkTlpReady), .tlpActive(tlpActive),
    .otherDllpPend(otherDllpPend), .txGrant_ff(txGrant_ff),
    .txGrantClass_ff(txGrantClass_ff), .txGrantDataCred_ff(txGrantDataCred_ff),
    .fcInit(fcInit), .fcRxUpd(fcRxUpd), .fcRxClass(fcRxClass),
    .fcRxHdr(fcRxHdr), .fcRxData(fcRxData), .rxRecv(rxRecv),
    .rxRecvClass(rxRecvClass), .rxRecvDataCred(rxRecvDataCred),
    .rxDrain(rxDrain), .rxDrainClass(rxDrainClass),
    .rxDrainDataCred(rxDrainDataCred), .fcReq_ff(fcReq_ff),
    .fcHiPri_ff(fcHiPri_ff), .fcClass_ff(fcClass_ff), .fcHdr_ff(fcHdr_ff),
    .fcData_ff(fcData_ff), .fcAck(fcAck), .endpointMode(endpointMode),
    .tag64En(tag64En), .cplTagFree(cplTagFree), .tagsInUse_ff(tagsInUse_ff),
    .errValid(errValid), .errSev(errSev), .errCorr_ff(errCorr_ff),
    .errNonFatal_ff(errNonFatal_ff), .errFatal_ff(errFatal_ff));
  pfc_link_model u_link (.clk(clk), .rst_b(rst_b), .fcReq(fcReq_ff),
    .fcAck_ff(fcAck), .stall(stall), .slow(slow),
    .linkTlpReady(linkTlpReady));
  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (txGrant_ff === 1'b1) gCnt++;
    if (cyc == 4000) begin
      n_errors++;
      test_done;
    end
  end
  // ****************************************
  // Bus tasks
  // ****************************************
  task push(input [1:0] c, input [11:0] d, input r);
    int k;
    @(negedge clk);
    txReqValid = 1'b1;
    txReqClass = c;
    txReqDataCred = d;
    txReqIsRead = r;
    for (k = 0; k < 60 && txReqReady !== 1'b1; k++) @(negedge clk);
    `CHK(txReqReady, 1'b1)
    @(negedge clk);
    txReqValid = 1'b0;
  endtask
  task fcIn(input i, input [1:0] c, input [7:0] h, input [11:0] d);
    @(negedge clk);
    fcInit = i;
    fcRxUpd = !i;
    fcRxClass = c;
    fcRxHdr = h;
    fcRxData = d;
    @(negedge clk);
    fcInit = 1'b0;
    fcRxUpd = 1'b0;
  endtask
  task rxEv(input rcv, input [11:0] d);
    @(negedge clk);
    rxRecv = rcv;
    rxDrain = !rcv;
    rxRecvDataCred = d;
    rxDrainDataCred = d;
    @(negedge clk);
    rxRecv = 1'b0;
    rxDrain = 1'b0;
  endtask
  task waitGrant(input int n);
    int k;
    for (k = 0; k < 12 && gCnt != n; k++) @(negedge clk);
    `CHK(gCnt, n)
  endtask
  task waitReq;
    int k;
    for (k = 0; k < 40 && fcReq_ff !== 1'b1; k++) @(negedge clk);
    `CHK(fcReq_ff, 1'b1)
  endtask
  task expectUpd(input [1:0] c, input [7:0] h, input [11:0] d);
    int k;
    `CHK(fcClass_ff, c)
    `CHK(fcHdr_ff, h)
    `CHK(fcData_ff, d)
    for (k = 0; k < 40 && fcReq_ff === 1'b1; k++) @(negedge clk);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task sc_reset;
    repeat (2) @(negedge clk);
    `CHK(txReqReady, 1'b0)
    `CHK(fcReq_ff, 1'b0)
    `CHK(tagsInUse_ff, 7'h00)
    rst_b = 1'b1;
  endtask
  task sc_timer;
    int k;
    for (k = 0; k < 1230 && fcReq_ff !== 1'b1; k++) @(negedge clk);
    `CHK(k > 1190 && k < 1210, 1'b1)
    `CHK(fcHiPri_ff, 1'b1)
    expectUpd(`PFC_CLS_P, 8'h20, 12'h100);
    repeat (20) @(negedge clk);
  endtask
  task sc_credit;
    push(`PFC_CLS_P, 12'h003, 1'b0);
    repeat (6) @(negedge clk);
    `CHK(gCnt, 0)
    fcIn(1'b1, `PFC_CLS_P, 8'h02, 12'h004);
    waitGrant(1);
    `CHK(txGrantClass_ff, `PFC_CLS_P)
    `CHK(txGrantDataCred_ff, 12'h003)
    push(`PFC_CLS_P, 12'h002, 1'b0);
    repeat (6) @(negedge clk);
    `CHK(gCnt, 1)
    fcIn(1'b0, `PFC_CLS_P, 8'h02, 12'h008);
    waitGrant(2);
    push(`PFC_CLS_P, 12'h000, 1'b0);
    repeat (6) @(negedge clk);
    `CHK(gCnt, 2)
    fcIn(1'b0, `PFC_CLS_P, 8'h03, 12'h008);
    waitGrant(3);
  endtask
  task sc_update;
    @(negedge clk);
    otherDllpPend = 1'b1;
    rxEv(1'b0, 12'h004);
    repeat (6) @(negedge clk);
    `CHK(fcReq_ff, 1'b0)
    otherDllpPend = 1'b0;
    tlpActive = 1'b1;
    repeat (6) @(negedge clk);
    `CHK(fcReq_ff, 1'b0)
    tlpActive = 1'b0;
    waitReq;
    `CHK(fcHiPri_ff, 1'b0)
    expectUpd(`PFC_CLS_P, 8'h21, 12'h104);
    // Quarter of the data buffer freed at once, link acks slowly
    otherDllpPend = 1'b1;
    slow = 1'b1;
    rxEv(1'b0, 12'h040);
    waitReq;
    `CHK(fcHiPri_ff, 1'b1)
    expectUpd(`PFC_CLS_P, 8'h22, 12'h144);
    // Sender left with eight credits of data
    rxEv(1'b1, 12'h13c);
    rxEv(1'b0, 12'h001);
    waitReq;
    `CHK(fcHiPri_ff, 1'b1)
    expectUpd(`PFC_CLS_P, 8'h23, 12'h145);
    otherDllpPend = 1'b0;
    slow = 1'b0;
  endtask
  task sc_tags;
    int i;
    fcIn(1'b1, `PFC_CLS_CPL, 8'h00, 12'h000);
    stall = 1'b1;
    for (i = 0; i < 8; i++) push(`PFC_CLS_CPL, 12'hfff, 1'b1);
    @(negedge clk);
    `CHK(txReqReady, 1'b0)
    `CHK(gCnt, 3)
    stall = 1'b0;
    waitGrant(11);
    for (i = 0; i < 24; i++) push(`PFC_CLS_CPL, 12'hfff, 1'b1);
    waitGrant(35);
    `CHK(tagsInUse_ff, 7'h20)
    push(`PFC_CLS_CPL, 12'h001, 1'b1);
    repeat (8) @(negedge clk);
    `CHK(gCnt, 35)
    cplTagFree = 1'b1;
    @(negedge clk);
    cplTagFree = 1'b0;
    waitGrant(36);
    `CHK(tagsInUse_ff, 7'h20)
    // Wider tag limit lets one more read through
    tag64En = 1'b1;
    push(`PFC_CLS_CPL, 12'h001, 1'b1);
    waitGrant(37);
    `CHK(tagsInUse_ff, 7'h21)
    // Outside endpoint mode the expired completion timer must advertise
    endpointMode = 1'b0;
    waitReq;
    `CHK(fcHiPri_ff, 1'b1)
    expectUpd(`PFC_CLS_CPL, 8'h40, 12'h100);
  endtask
  task sc_err;
    int s;
    for (s = 0; s < 4; s++) begin
      @(negedge clk);
      errValid = 1'b1;
      errSev = s[1:0];
      @(negedge clk);
      errValid = 1'b0;
      `CHK(errCorr_ff, s == 1)
      `CHK(errNonFatal_ff, s == 2)
      `CHK(errFatal_ff, s == 3)
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    rst_b = 1'b0;
    {txReqValid, txReqIsRead, tlpActive, otherDllpPend, fcInit, fcRxUpd,
      rxRecv, rxDrain, tag64En, cplTagFree, errValid, stall, slow} = '0;
    {txReqClass, fcRxClass, errSev, fcRxHdr, txReqDataCred, fcRxData} = '0;
    {rxRecvDataCred, rxDrainDataCred, rxRecvClass, rxDrainClass} = '0;
    endpointMode = 1'b1;
    sc_reset;
    sc_timer;
    sc_credit;
    sc_update;
    sc_tags;
    sc_err;
    test_done;
  end
endmodule // pfc_top_tb
bind pfc_top pfc_top_monitor u_mon (.clk(clk), .rst_b(rst_b),
  .linkTlpReady(linkTlpReady), .tlpActive(tlpActive),
  .otherDllpPend(otherDllpPend), .endpointMode(endpointMode),
  .tag64En(tag64En), .errValid(errValid), .errSev(errSev), .fcAck(fcAck),
  .txGrant_ff(txGrant_ff), .fcReq_ff(fcReq_ff), .fcHiPri_ff(fcHiPri_ff),
  .fcClass_ff(fcClass_ff), .fcHdr_ff(fcHdr_ff), .fcData_ff(fcData_ff),
  .tagsInUse_ff(tagsInUse_ff), .errCorr_ff(errCorr_ff),
  .errNonFatal_ff(errNonFatal_ff), .errFatal_ff(errFatal_ff));
